// >>> sim/fas_far_end.sv
// trigger sources and transfer sink facing the sequencer
`timescale 1ns/1ps
module fas_far_end (
  // clock
  input wire logic clk_i,
  // bench requests
  input wire logic [4:0] fire_i,
  input wire logic [3:0] lag_i,
  // sequencer side
  input wire logic readout_i,
  output logic [4:0] trig_o,
  output logic xfer_done_o
);
  logic prev_rd; // readout level one cycle ago
  int left; // cycles until the transfer of a frame ends
  // triggers are one-cycle pulses; transfer done pulses lag + 3 cycles after readout ends
  always_ff @(posedge clk_i)
  begin
    trig_o <= fire_i;
    prev_rd <= readout_i;
    xfer_done_o <= (left == 1);
    if (prev_rd === 1'b1 && readout_i === 1'b0)
      left <= lag_i + 2;
    else if (left > 0)
      left <= left - 1;
  end
endmodule : fas_far_end

// >>> sim/frame_acquisition_sequencer_tb.sv
// self-checking bench for the frame acquisition sequencer
`timescale 1ns/1ps
module frame_acquisition_sequencer_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, lvl = 1'b0, ack, xd;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [4:0] fire = 5'h00, trig;
  logic [3:0] lag;
  logic expo, rdo, lst, fst, aw, ar, at, fw, fr, frz, rd_q;
  int failures = 0, check_count = 0, cycles = 0, frames = 0, dones = 0;
  int n, k, lines = 0;
  // reset values, last entry an unmapped place
  logic [7:0] adrs[5] = '{fas_pkg::REG_CTRL, fas_pkg::REG_ACQ_CNT,
    fas_pkg::REG_FRM_PER, fas_pkg::REG_GEOM, 8'h3c};
  logic [31:0] vals[5] = '{fas_pkg::CTRL_RST, {16'h0, fas_pkg::CNT_RST},
    {16'h0, fas_pkg::FRM_PER_RST}, {16'h0, fas_pkg::GEOM_RST}, 32'h0};

  fas_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat),
    .dat_o(rdat), .ack_o(ack), .acq_trig_i(trig[0]), .frm_trig_i(trig[1]),
    .line_trig_i(trig[2]), .burst_begin_trigger_i(trig[3]),
    .burst_finish_trigger_i(trig[4]), .burst_level_trigger_i(lvl),
    .xfer_done_i(xd), .exposing_o(expo), .readout_o(rdo),
    .line_strobe_o(lst), .frame_start_o(fst), .acq_waiting_trigger_o(aw),
    .acq_running_o(ar), .acq_transferring_o(at),
    .frm_waiting_trigger_o(fw), .frm_running_o(fr),
    .transport_params_frozen_o(frz));
  fas_far_end far_u (.clk_i(clk_i), .fire_i(fire), .lag_i(lag),
    .readout_i(rdo), .trig_o(trig), .xfer_done_o(xd));

  always #50 clk_i = ~clk_i;

  // frame and readout counters, plus the hang limit
  always @(posedge clk_i)
  begin
    cycles++;
    if (fst === 1'b1) frames++;
    if (lst === 1'b1) lines++;
    if (rd_q === 1'b1 && rdo === 1'b0) dones++;
    rd_q <= rdo;
    if (cycles == 30000)
    begin
      failures++;
      end_of_test();
    end
  end

  // frames an untriggered acquisition should give, -1 for unlimited
  function automatic int model(input int m, input int cnt);
    return (m == 0) ? 1 : (m == 1) ? cnt : -1;
  endfunction : model

  task automatic chk(input string s, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  // classic single cycle; waits for ack, no assumed latency
  task automatic wb(input logic w, input logic [7:0] a, input int d);
    k = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    if (k == 40) failures++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic cmd(input int b);
    wb(1'b1, fas_pkg::REG_CMD, 1 << b);
  endtask : cmd

  task automatic pulse(input int b);
    fire <= 5'h01 << b;
    @(posedge clk_i);
    fire <= 5'h00;
  endtask : pulse

  // bounded wait for idle, then let pending transfers drain
  task automatic idle_wait();
    for (k = 0; k < 800 && ar !== 1'b0; k++) @(posedge clk_i);
    if (k == 800) failures++;
    repeat (40) @(posedge clk_i);
    chk("transfer level", at, 0);
  endtask : idle_wait

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    void'($urandom(10));
    lag = 4'($urandom % 12);
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (adrs[i])
    begin
      wb(1'b0, adrs[i], 0);
      chk("reset value", q, vals[i]);
    end
    wb(1'b1, fas_pkg::REG_GEOM, 2);
    wb(1'b1, fas_pkg::REG_LINE_PER, 4);
    wb(1'b1, fas_pkg::REG_EXPO, 2);
    wb(1'b1, fas_pkg::REG_FRM_PER, 32'h20);
    $display("test registers done");
    // one-shot and counted, settings frozen by arm
    for (int m = 0; m < 2; m++)
    begin
      n = 2 + $urandom % 3;
      wb(1'b1, fas_pkg::REG_CTRL, m);
      wb(1'b1, fas_pkg::REG_ACQ_CNT, n);
      cmd(fas_pkg::CMD_ARM);
      chk("frozen", frz, 1);
      wb(1'b1, fas_pkg::REG_ACQ_CNT, n + 1);
      frames = 0;
      cmd(fas_pkg::CMD_START);
      idle_wait();
      chk("frame count", frames, model(m, n));
      chk("unfrozen", frz, 0);
    end
    $display("test modes done");
    // free run, status readback, stop ends after the frame
    wb(1'b1, fas_pkg::REG_CTRL, 2);
    frames = 0;
    dones = 0;
    cmd(fas_pkg::CMD_START);
    wb(1'b1, fas_pkg::REG_STAT_SEL, fas_pkg::SEL_ACQ_RUN);
    wb(1'b0, fas_pkg::REG_STAT_VAL, 0);
    chk("status", q, 1);
    repeat (120) @(posedge clk_i);
    cmd(fas_pkg::CMD_STOP);
    idle_wait();
    chk("whole frames", dones, frames);
    chk("rate", frames > 2, 1);
    // abort in mid readout
    cmd(fas_pkg::CMD_START);
    for (k = 0; k < 200 && rdo !== 1'b1; k++) @(posedge clk_i);
    chk("reach readout", k < 200, 1);
    cmd(fas_pkg::CMD_ABORT);
    @(posedge clk_i);
    chk("abort readout", rdo, 0);
    chk("abort run", ar, 0);
    $display("test stop_abort done");
    // stop while waiting for a frame trigger
    wb(1'b1, fas_pkg::REG_CTRL, 32'h0a);
    frames = 0;
    cmd(fas_pkg::CMD_START);
    repeat (5) @(posedge clk_i);
    chk("frame wait", fw, 1);
    cmd(fas_pkg::CMD_STOP);
    idle_wait();
    chk("cancelled", frames, 0);
    // one-shot behind an acquisition trigger
    wb(1'b1, fas_pkg::REG_CTRL, 32'h04);
    cmd(fas_pkg::CMD_START);
    repeat (40) @(posedge clk_i);
    chk("acq wait", aw, 1);
    pulse(0);
    idle_wait();
    chk("one per trigger", frames, 1);
    // line-scan one-shot: one frame boundary, one strobe per line
    wb(1'b1, fas_pkg::REG_CTRL, 32'h80);
    frames = 0;
    lines = 0;
    cmd(fas_pkg::CMD_START);
    chk("exposing", expo, 1);
    chk("frame run", fr, 1);
    idle_wait();
    chk("line frames", frames, 1);
    chk("line strobes", lines, 2);
    $display("test triggers done");
    // counted bursts, two begin triggers
    n = 1 + $urandom % 3;
    frames = 0;
    wb(1'b1, fas_pkg::REG_BURST_CNT, n);
    wb(1'b1, fas_pkg::REG_CTRL, 32'h12);
    cmd(fas_pkg::CMD_START);
    for (int b = 1; b < 3; b++)
    begin
      pulse(3);
      repeat (300) @(posedge clk_i);
      chk("burst frames", frames, b * n);
    end
    cmd(fas_pkg::CMD_ABORT);
    // begin/finish delimited, then level gated bursts
    for (int c = 0; c < 2; c++)
    begin
      wb(1'b1, fas_pkg::REG_CTRL, c ? 32'h42 : 32'h32);
      frames = 0;
      cmd(fas_pkg::CMD_START);
      if (c) lvl <= 1'b1;
      else pulse(3);
      repeat (100) @(posedge clk_i);
      if (c) lvl <= 1'b0;
      else pulse(4);
      repeat (60) @(posedge clk_i);
      n = frames;
      repeat (150) @(posedge clk_i);
      chk("burst ended", frames, n);
      chk("burst ran", n > 0, 1);
      cmd(fas_pkg::CMD_ABORT);
    end
    $display("test bursts done");
    end_of_test();
  end
endmodule : frame_acquisition_sequencer_tb

// >>> verilog/fas_counter.sv
// loadable down counter with zero flag
`timescale 1ns/1ps
module fas_counter #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [W-1:0] value_i,
  input wire logic dec_i,
  // state
  output logic zero_o,
  output logic [W-1:0] count_o
);
  logic [W-1:0] count;

  // load wins over decrement; holds at zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= '0;
    else if (load_i)
      count <= value_i;
    else if (dec_i && count != '0)
      count <= count - W'(1);
  end

  assign zero_o = (count == '0);
  assign count_o = count;
endmodule : fas_counter

// >>> verilog/fas_pkg.sv
// constants and types for the frame acquisition sequencer
// Overview of operation
// - acquisition is frames of lines, optional bursts
// - burst trigger gating splits acquisition into bursts
// - begin-trigger only: burst holds frames_per_burst frames
// - begin and finish triggers delimit each burst
// - level trigger: capture while it stays high
// - transfer spans first transfer start to last end
// - frame: optional exposure, then readout of lines
// - line-scan: expose and read each line separately
// - mode sets frames: one, counted, unlimited
// - arm validates and freezes capture parameters (here arm only freezes them; nothing is validated)
// - start begins now or waits for trigger
// - stop finishes current frame then ends
// - stop while waiting cancels pending frame
// - abort ends capture at once
// - counted mode captures frames_per_acq frames
// - untriggered frames follow frame_rate_setting (here only with no trigger enabled; any_trig skips the rate wait)
// - untriggered lines follow line_rate_setting
// - six status signals readable through selector
// - one-shot with start trigger: one frame per trigger (here the run goes idle after the first triggered frame)
package fas_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_ACQ_CNT = 8'h08;
  localparam logic [7:0] REG_BURST_CNT = 8'h0c;
  localparam logic [7:0] REG_FRM_PER = 8'h10;
  localparam logic [7:0] REG_LINE_PER = 8'h14;
  localparam logic [7:0] REG_GEOM = 8'h18;
  localparam logic [7:0] REG_EXPO = 8'h1c;
  localparam logic [7:0] REG_STAT_SEL = 8'h20;
  localparam logic [7:0] REG_STAT_VAL = 8'h24;
  localparam logic [7:0] REG_STATE = 8'h28;
  // control field positions
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_ACQ_TRIG = 2;
  localparam int CTRL_FRM_TRIG = 3;
  localparam int CTRL_BEGIN_TRIG = 4;
  localparam int CTRL_FINISH_TRIG = 5;
  localparam int CTRL_LEVEL_TRIG = 6;
  localparam int CTRL_LINE_SCAN = 7;
  localparam int CTRL_LINE_TRIG = 8;
  // command bit positions
  localparam int CMD_ARM = 0;
  localparam int CMD_START = 1;
  localparam int CMD_STOP = 2;
  localparam int CMD_ABORT = 3;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam logic [15:0] FRM_PER_RST = 16'h0100;
  localparam logic [15:0] LINE_PER_RST = 16'h0004;
  localparam logic [15:0] GEOM_RST = 16'h0004;
  localparam logic [15:0] EXPO_RST = 16'h0002;
  // capture modes
  typedef enum logic [1:0] {
    one_shot_mode = 2'h0,
    counted_mode = 2'h1,
    free_run_mode = 2'h2
  } fas_mode_t;
  // status selector codes
  localparam logic [2:0] SEL_ACQ_WAIT = 3'h0;
  localparam logic [2:0] SEL_ACQ_RUN = 3'h1;
  localparam logic [2:0] SEL_ACQ_XFER = 3'h2;
  localparam logic [2:0] SEL_FRM_WAIT = 3'h3;
  localparam logic [2:0] SEL_FRM_RUN = 3'h4;
  localparam logic [2:0] SEL_EXPOSING = 3'h5;
endpackage : fas_pkg

// >>> verilog/fas_sequencer.sv
// frame acquisition sequencer top: modes, commands, bursts, timing
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module fas_sequencer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // trigger inputs, one-cycle pulses except the level trigger
  input wire logic acq_trig_i,
  input wire logic frm_trig_i,
  input wire logic line_trig_i,
  input wire logic burst_begin_trigger_i,
  input wire logic burst_finish_trigger_i,
  input wire logic burst_level_trigger_i,
  // transfer path handshake
  input wire logic xfer_done_i,
  // sensor path
  output logic exposing_o,
  output logic readout_o,
  output logic line_strobe_o,
  output logic frame_start_o,
  // status levels
  output logic acq_waiting_trigger_o,
  output logic acq_running_o,
  output logic acq_transferring_o,
  output logic frm_waiting_trigger_o,
  output logic frm_running_o,
  output logic transport_params_frozen_o
);
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_ACQ_WAIT, S_BURST_WAIT, S_FRM_WAIT, S_RATE_WAIT,
    S_EXPOSE, S_READOUT
  } fas_state_t;

  fas_state_t state, next_state;
  logic [31:0] ctrl;
  logic [15:0] acq_cnt, burst_cnt, frm_per, line_per, geom, expo;
  logic [2:0] stat_sel;
  logic [3:0] cmd;
  logic stop_pend;      // stop seen, finish frame first
  logic frozen;         // parameters locked by arm or start
  logic in_burst;       // burst currently open
  logic [15:0] xfer_out; // frames readout but not yet transferred
  logic stat_val;

  // settings, decoded
  wire fas_pkg::fas_mode_t mode =
    fas_pkg::fas_mode_t'(ctrl[fas_pkg::CTRL_MODE_LO +: 2]);
  wire acq_trig_on = ctrl[fas_pkg::CTRL_ACQ_TRIG];
  wire frm_trig_on = ctrl[fas_pkg::CTRL_FRM_TRIG];
  wire begin_on = ctrl[fas_pkg::CTRL_BEGIN_TRIG];
  wire finish_on = ctrl[fas_pkg::CTRL_FINISH_TRIG];
  wire level_on = ctrl[fas_pkg::CTRL_LEVEL_TRIG];
  wire line_scan = ctrl[fas_pkg::CTRL_LINE_SCAN];
  wire line_trig_on = ctrl[fas_pkg::CTRL_LINE_TRIG];
  wire any_trig = acq_trig_on | frm_trig_on | begin_on | level_on;
  wire burst_mode = begin_on | level_on;
  wire arm_c = cmd[fas_pkg::CMD_ARM];
  wire start_c = cmd[fas_pkg::CMD_START];
  wire stop_c = cmd[fas_pkg::CMD_STOP];
  wire abort_c = cmd[fas_pkg::CMD_ABORT];

  fas_wb_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .ctrl_o(ctrl),
    .acq_cnt_o(acq_cnt),
    .burst_cnt_o(burst_cnt),
    .frm_per_o(frm_per),
    .line_per_o(line_per),
    .geom_o(geom),
    .expo_o(expo),
    .stat_sel_o(stat_sel),
    .cmd_o(cmd),
    .stat_val_i(stat_val),
    .state_i({16'h0000, xfer_out[7:0], 5'h00, 3'(state)}),
    .frozen_i(frozen)
  );

  // counters: frames left, burst frames left, rate, lines, exposure
  logic acq_zero, burst_zero, rate_zero, line_zero, tim_zero;
  logic [15:0] acq_left, burst_left, unused_r, unused_l, unused_t;
  // a frame begins once; line-scan returns to exposure are not frames
  wire frm_begin = (state != S_EXPOSE) && (state != S_READOUT) &&
                   (next_state == S_EXPOSE);
  wire frm_end = (state == S_READOUT) && (next_state != S_READOUT)
                 && (next_state != S_EXPOSE || !line_scan);
  // line boundary: readout of one line finished
  wire line_done = (state == S_READOUT) && tim_zero;
  wire leave_idle = (state == S_IDLE) && (next_state != S_IDLE);
  wire burst_open = (state == S_BURST_WAIT) && (next_state != S_BURST_WAIT);

  fas_counter u_acq (
    .clk_i(clk_i), .rst_i(rst_i),
    .load_i(leave_idle), .value_i(acq_cnt),
    .dec_i(frm_end && mode == fas_pkg::counted_mode),
    .zero_o(acq_zero), .count_o(acq_left)
  );
  fas_counter u_burst (
    .clk_i(clk_i), .rst_i(rst_i),
    .load_i(burst_open), .value_i(burst_cnt),
    .dec_i(frm_end), .zero_o(burst_zero), .count_o(burst_left)
  );
  // frame period counter, reloaded at each frame begin
  fas_counter u_rate (
    .clk_i(clk_i), .rst_i(rst_i),
    .load_i(frm_begin), .value_i(frm_per),
    .dec_i(1'b1), .zero_o(rate_zero), .count_o(unused_r)
  );
  // lines left in frame
  fas_counter u_line (
    .clk_i(clk_i), .rst_i(rst_i),
    .load_i(frm_begin && state != S_READOUT), .value_i(geom),
    .dec_i(line_done), .zero_o(line_zero), .count_o(unused_l)
  );
  // phase timer: exposure length, then per-line readout period
  wire tim_load = (next_state == S_EXPOSE && state != S_EXPOSE) ||
                  (next_state == S_READOUT && state != S_READOUT) ||
                  (line_done && next_state == S_READOUT);
  wire [15:0] tim_val = (next_state == S_EXPOSE) ? expo : line_per;
  fas_counter u_tim (
    .clk_i(clk_i), .rst_i(rst_i),
    .load_i(tim_load), .value_i(tim_val),
    .dec_i(1'b1), .zero_o(tim_zero), .count_o(unused_t)
  );

  // line pacing: phase timer when untriggered, else phase timer plus line trigger
  wire line_go = line_trig_on ? line_trig_i : 1'b1;
  wire last_line = line_done && (unused_l == 16'h0001);
  // acquisition complete after this frame
  wire acq_last = (mode == fas_pkg::one_shot_mode) ||
                  (mode == fas_pkg::counted_mode &&
                   acq_left == 16'h0001);
  // burst closes after this frame
  wire burst_last = level_on ? !burst_level_trigger_i :
                    finish_on ? 1'b0 : (burst_left == 16'h0001);
  // where to go after a frame
  wire fas_state_t after_frame =
    (stop_pend || stop_c || acq_last) ? S_IDLE :
    (acq_trig_on && mode == fas_pkg::one_shot_mode) ? S_ACQ_WAIT :
    (burst_mode && (burst_last || !in_burst)) ? S_BURST_WAIT :
    frm_trig_on ? S_FRM_WAIT : S_RATE_WAIT;
  wire fas_state_t frame_entry =
    burst_mode ? S_BURST_WAIT : frm_trig_on ? S_FRM_WAIT : S_EXPOSE;

  // next-state logic
  always_comb
  begin
    next_state = state;
    if (abort_c)
      next_state = S_IDLE;
    else
    begin
      unique case (state)
        S_IDLE:
          if (start_c)
            next_state = acq_trig_on ? S_ACQ_WAIT : frame_entry;
        S_ACQ_WAIT:
          if (stop_c)
            next_state = S_IDLE;
          else if (acq_trig_i)
            next_state = frame_entry;
        S_BURST_WAIT:
          if (stop_c)
            next_state = S_IDLE;
          else if (level_on ? burst_level_trigger_i : burst_begin_trigger_i)
            next_state = frm_trig_on ? S_FRM_WAIT : S_EXPOSE;
        S_FRM_WAIT:
          if (stop_c)
            next_state = S_IDLE;
          else if (burst_mode && finish_on && burst_finish_trigger_i)
            next_state = S_BURST_WAIT;
          else if (frm_trig_i)
            next_state = S_EXPOSE;
        S_RATE_WAIT:
          if (stop_c)
            next_state = S_IDLE;
          else if (burst_mode && finish_on && !in_burst)
            next_state = S_BURST_WAIT;
          else if (rate_zero || any_trig)
            next_state = S_EXPOSE;
        S_EXPOSE:
          if (tim_zero)
            next_state = S_READOUT;
        S_READOUT:
          if (tim_zero && line_go)
          begin
            if (last_line || !line_scan)
              next_state = (last_line || !line_scan) && unused_l <= 16'h0001
                           ? after_frame : S_READOUT;
            else
              next_state = S_EXPOSE;
          end
      endcase
    end
  end

  // state register plus stop, lock and burst flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      stop_pend <= 1'b0;
      frozen <= 1'b0;
      in_burst <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // stop during a frame waits for the frame to end
      stop_pend <= (next_state != S_IDLE) && (stop_pend || stop_c);
      // arm holds the lock in idle until start; stop, abort or run end clear
      frozen <= arm_c || start_c || next_state != S_IDLE ||
                (frozen && state == S_IDLE && !stop_c && !abort_c);
      if (burst_open)
        in_burst <= 1'b1;
      else if ((finish_on && burst_finish_trigger_i) ||
               (frm_end && burst_last) || next_state == S_IDLE)
        in_burst <= 1'b0;
    end
  end

  // frames awaiting transfer; a frame end and a done in the same cycle cancel, count holds
  always_ff @(posedge clk_i)
  begin
    if (rst_i || abort_c)
      xfer_out <= 16'h0000;
    else if (frm_end && !(xfer_done_i && xfer_out != 16'h0000))
      xfer_out <= xfer_out + 16'h0001;
    else if (!frm_end && xfer_done_i && xfer_out != 16'h0000)
      xfer_out <= xfer_out - 16'h0001;
  end

  // status selector readback
  always_comb
  begin
    unique case (stat_sel)
      fas_pkg::SEL_ACQ_WAIT: stat_val = acq_waiting_trigger_o;
      fas_pkg::SEL_ACQ_RUN: stat_val = acq_running_o;
      fas_pkg::SEL_ACQ_XFER: stat_val = acq_transferring_o;
      fas_pkg::SEL_FRM_WAIT: stat_val = frm_waiting_trigger_o;
      fas_pkg::SEL_FRM_RUN: stat_val = frm_running_o;
      fas_pkg::SEL_EXPOSING: stat_val = exposing_o;
      default: stat_val = 1'b0;
    endcase
  end

  // status and sensor outputs, all but line strobe and frame start from state registers
  assign acq_waiting_trigger_o = (state == S_ACQ_WAIT);
  assign acq_running_o = (state != S_IDLE) && (state != S_ACQ_WAIT);
  assign acq_transferring_o = (xfer_out != 16'h0000);
  assign frm_waiting_trigger_o = (state == S_FRM_WAIT) ||
                                 (state == S_BURST_WAIT);
  assign frm_running_o = (state == S_EXPOSE) || (state == S_READOUT);
  assign exposing_o = (state == S_EXPOSE);
  assign readout_o = (state == S_READOUT);
  assign line_strobe_o = line_done && line_go;
  assign frame_start_o = frm_begin;
  assign transport_params_frozen_o = frozen;

  // after abort the sequencer sits idle next cycle
  a_abort_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    abort_c |=> state == S_IDLE) else $error("abort not idle");
  // stop while waiting for a trigger cancels the frame
  a_stop_cancel: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_c && !abort_c && state == S_FRM_WAIT |=> state == S_IDLE)
    else $error("pending frame kept");
  // exposure always leads into readout
  sequence s_expose_end;
    state == S_EXPOSE && tim_zero && !abort_c;
  endsequence
  a_expose_read: assert property (@(posedge clk_i) disable iff (rst_i)
    s_expose_end |=> state == S_READOUT) else $error("no readout");
  // stop during readout never jumps straight to idle mid-frame
  a_stop_finish: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_READOUT && !tim_zero && !abort_c |=> state == S_READOUT)
    else $error("frame cut short");
  // one-shot frame returns to idle
  a_one_shot: assert property (@(posedge clk_i) disable iff (rst_i)
    frm_end && mode == fas_pkg::one_shot_mode && !acq_trig_on && !abort_c
    |=> state == S_IDLE) else $error("one-shot ran on");
  // counted mode ends after the last frame
  a_count_end: assert property (@(posedge clk_i) disable iff (rst_i)
    frm_end && mode == fas_pkg::counted_mode && acq_left == 16'h0001
    |=> !acq_running_o) else $error("count overrun");
  // start with no trigger begins a frame at once
  a_start_now: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_IDLE && start_c && !abort_c && !any_trig
    |=> exposing_o) else $error("start idle");
  // parameters frozen whenever a run is active
  a_frozen_run: assert property (@(posedge clk_i) disable iff (rst_i)
    acq_running_o |-> frozen) else $error("params unfrozen");
  // selector mirrors exposure status
  a_stat_expo: assert property (@(posedge clk_i) disable iff (rst_i)
    stat_sel == fas_pkg::SEL_EXPOSING |-> stat_val == exposing_o)
    else $error("status mismatch");
endmodule : fas_sequencer

// >>> verilog/fas_wb_regs.sv
// wishbone classic slave for sequencer settings and status
`timescale 1ns/1ps
module fas_wb_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // settings
  output logic [31:0] ctrl_o,
  output logic [15:0] acq_cnt_o,
  output logic [15:0] burst_cnt_o,
  output logic [15:0] frm_per_o,
  output logic [15:0] line_per_o,
  output logic [15:0] geom_o,
  output logic [15:0] expo_o,
  output logic [2:0] stat_sel_o,
  output logic [3:0] cmd_o,
  // readback
  input wire logic stat_val_i,
  input wire logic [31:0] state_i,
  input wire logic frozen_i
);
  logic [31:0] ctrl;
  logic [15:0] acq_cnt, burst_cnt, frm_per, line_per, geom, expo;
  logic [2:0] stat_sel;
  logic [31:0] rdata;
  logic ack;
  // one access per request; ack for one cycle then drop
  wire req = cyc_i && stb_i && !ack;
  wire wr = req && we_i && sel_i[0];
  // frozen settings ignore writes while locked
  wire wr_cfg = wr && !frozen_i;
  wire [15:0] w16 = {sel_i[1] ? dat_i[15:8] : 8'h00, dat_i[7:0]};

  // settings storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= fas_pkg::CTRL_RST;
      acq_cnt <= fas_pkg::CNT_RST;
      burst_cnt <= fas_pkg::CNT_RST;
      frm_per <= fas_pkg::FRM_PER_RST;
      line_per <= fas_pkg::LINE_PER_RST;
      geom <= fas_pkg::GEOM_RST;
      expo <= fas_pkg::EXPO_RST;
      stat_sel <= 3'h0;
    end
    else if (wr_cfg)
    begin
      unique case (adr_i)
        fas_pkg::REG_CTRL: ctrl <= {16'h0000, w16};
        fas_pkg::REG_ACQ_CNT: acq_cnt <= w16;
        fas_pkg::REG_BURST_CNT: burst_cnt <= w16;
        fas_pkg::REG_FRM_PER: frm_per <= w16;
        fas_pkg::REG_LINE_PER: line_per <= w16;
        fas_pkg::REG_GEOM: geom <= w16;
        fas_pkg::REG_EXPO: expo <= w16;
        fas_pkg::REG_STAT_SEL: stat_sel <= dat_i[2:0];
        default: ;
      endcase
    end
    else if (wr && adr_i == fas_pkg::REG_STAT_SEL)
      stat_sel <= dat_i[2:0];
  end

  // read mux; unmapped reads return zero
  always_comb
  begin
    unique case (adr_i)
      fas_pkg::REG_CTRL: rdata = ctrl;
      fas_pkg::REG_ACQ_CNT: rdata = {16'h0000, acq_cnt};
      fas_pkg::REG_BURST_CNT: rdata = {16'h0000, burst_cnt};
      fas_pkg::REG_FRM_PER: rdata = {16'h0000, frm_per};
      fas_pkg::REG_LINE_PER: rdata = {16'h0000, line_per};
      fas_pkg::REG_GEOM: rdata = {16'h0000, geom};
      fas_pkg::REG_EXPO: rdata = {16'h0000, expo};
      fas_pkg::REG_STAT_SEL: rdata = {29'h0, stat_sel};
      fas_pkg::REG_STAT_VAL: rdata = {31'h0, stat_val_i};
      fas_pkg::REG_STATE: rdata = state_i;
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ack and registered read data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack <= req;
      dat_o <= req ? rdata : 32'h0000_0000;
    end
  end

  assign ack_o = ack;
  // command pulses: one cycle, only on a command write
  assign cmd_o = (wr && adr_i == fas_pkg::REG_CMD) ? dat_i[3:0] : 4'h0;
  assign ctrl_o = ctrl;
  assign acq_cnt_o = acq_cnt;
  assign burst_cnt_o = burst_cnt;
  assign frm_per_o = frm_per;
  assign line_per_o = line_per;
  assign geom_o = geom;
  assign expo_o = expo;
  assign stat_sel_o = stat_sel;
endmodule : fas_wb_regs
